// ### design/sbit_pkg.sv
/*
 * Shared constants and types of the sixteen-bit interval timer: register
 * offsets, field positions, reset values, alias operations and the
 * control-field carrier.
 * Assumes a 32-bit AXI4-Lite register bus with byte addresses.
 */
`default_nettype none

package sbit_pkg;

   // ==========================================================================
   // register map (byte addresses; CTRL, COUNT and PERIOD decode 16-byte alias banks, the rest one aligned word each)
   // ==========================================================================
   localparam int          SBIT_ADDR_W     = 8;
   localparam logic [7:0]  ADDR_CTRL       = 8'h00;
   localparam logic [7:0]  ADDR_COUNT      = 8'h10;
   localparam logic [7:0]  ADDR_PERIOD     = 8'h20;
   localparam logic [7:0]  ADDR_STATUS     = 8'h30;
   localparam logic [7:0]  ADDR_MASK       = 8'h34;
   localparam logic [7:0]  ADDR_CONFIG     = 8'h38;

   // ==========================================================================
   // timer_control field positions
   // ==========================================================================
   localparam int          CTRL_ON_BIT     = 15;
   localparam int          CTRL_IDLE_BIT   = 13;
   localparam int          CTRL_GATE_BIT   = 7;
   localparam int          CTRL_PS_LSB     = 4;
   localparam int          CTRL_PAIR_BIT   = 3;
   localparam int          CTRL_SRC_BIT    = 1;
   localparam logic [31:0] CTRL_WMASK      = 32'h0000_A0FA;
   localparam logic [31:0] CTRL_RST        = 32'h0000_0000;

   // ==========================================================================
   // other fields and reset values
   // ==========================================================================
   localparam int          CNT_W           = 16;
   localparam logic [15:0] PERIOD_RST      = 16'hFFFF;
   localparam int          ST_W            = 2;
   localparam int          ST_WRAP_BIT     = 0;
   localparam int          ST_GATE_BIT     = 1;
   localparam logic [1:0]  MASK_RST        = 2'h0;
   localparam int          CFG_ASYNC_BIT   = 0;
   localparam logic [1:0]  RESP_OKAY       = 2'h0;
   localparam logic [1:0]  RESP_SLVERR     = 2'h2;

   typedef enum logic [1:0] {
      OP_WRITE = 2'b00,
      OP_CLR   = 2'b01,
      OP_SET   = 2'b10,
      OP_INV   = 2'b11
   } sbit_op_t;

   typedef enum logic [2:0] {
      REG_CTRL   = 3'b000,
      REG_COUNT  = 3'b001,
      REG_PERIOD = 3'b010,
      REG_STATUS = 3'b011,
      REG_MASK   = 3'b100,
      REG_CONFIG = 3'b101,
      REG_NONE   = 3'b111
   } sbit_reg_t;

   typedef struct packed {
      logic       on;
      logic       stop_when_idle;
      logic       gate_en;
      logic [2:0] ps_sel;
      logic       pair;
      logic       clock_source_select;
   } sbit_ctrl_t;

   function automatic sbit_ctrl_t sbit_ctrl_of(input logic [31:0] w);
      sbit_ctrl_t c;
      c.on                  = w[CTRL_ON_BIT];
      c.stop_when_idle      = w[CTRL_IDLE_BIT];
      c.gate_en             = w[CTRL_GATE_BIT];
      c.ps_sel              = w[CTRL_PS_LSB +: 3];
      c.pair                = w[CTRL_PAIR_BIT];
      c.clock_source_select = w[CTRL_SRC_BIT];
      return c;
   endfunction

endpackage

`default_nettype wire

// ### design/sbit_prescaler.sv
/*
 * Prescaler of the interval timer: passes one of every 1, 2, 4, 8, 16, 32,
 * 64 or 256 source ticks.
 * Assumes tick_in is a one-cycle pulse in the clk domain.
 */
`timescale 1ns/1ns
`default_nettype none

module sbit_prescaler
   import sbit_pkg::*;
(
   input  wire logic       clk,      // system clock
   input  wire logic       rst,      // asynchronous reset, active high
   input  wire logic       clear,    // restart the division
   input  wire logic       tick_in,  // source tick
   input  wire logic [2:0] ps_sel,   // ratio code
   output logic            tick_out  // prescaled tick
);

   logic [7:0] cnt_q;
   logic [7:0] cnt_d;
   logic [7:0] last;

   // code 111 jumps to 1:256, not 1:128
   always_comb begin
      case (ps_sel)
         3'h0:    last = 8'h00;
         3'h1:    last = 8'h01;
         3'h2:    last = 8'h03;
         3'h3:    last = 8'h07;
         3'h4:    last = 8'h0F;
         3'h5:    last = 8'h1F;
         3'h6:    last = 8'h3F;
         default: last = 8'hFF;
      endcase
   end

   always_comb begin
      tick_out = tick_in && (cnt_q >= last);
      cnt_d    = cnt_q;
      if (clear) begin
         cnt_d = 8'h00;
      end else if (tick_out) begin
         cnt_d = 8'h00;
      end else if (tick_in) begin
         cnt_d = cnt_q + 8'h01;
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         cnt_q <= 8'h00;
      end else begin
         cnt_q <= cnt_d;
      end
   end

endmodule

`default_nettype wire

// ### design/sbit_timer.sv
/*
 * Sixteen-bit interval timer with an AXI4-Lite register slave, clear/set/
 * invert aliases, period wrap and a masked level interrupt.
 * Assumes external event, gate and secondary-oscillator inputs are already
 * synchronous to clk; the oscillator is seen as a pulse stream.
 */
`timescale 1ns/1ns
`default_nettype none

module sbit_timer
   import sbit_pkg::*;
#(
   parameter int CW = CNT_W                     // counter width
)(
   input  wire logic                   clk,      // system clock, 125 MHz
   input  wire logic                   rst,      // asynchronous reset
   input  wire logic                   s_axi_awvalid, // write address valid
   output logic                        s_axi_awready, // write address ready
   input  wire logic [SBIT_ADDR_W-1:0] s_axi_awaddr,  // write address
   input  wire logic                   s_axi_wvalid,  // write data valid
   output logic                        s_axi_wready,  // write data ready
   input  wire logic [31:0]            s_axi_wdata,   // write data
   input  wire logic [3:0]             s_axi_wstrb,   // byte enables
   output logic                        s_axi_bvalid,  // write response valid
   input  wire logic                   s_axi_bready,  // write response ready
   output logic [1:0]                  s_axi_bresp,   // write response
   input  wire logic                   s_axi_arvalid, // read address valid
   output logic                        s_axi_arready, // read address ready
   input  wire logic [SBIT_ADDR_W-1:0] s_axi_araddr,  // read address
   output logic                        s_axi_rvalid,  // read data valid
   input  wire logic                   s_axi_rready,  // read data ready
   output logic [31:0]                 s_axi_rdata,   // read data
   output logic [1:0]                  s_axi_rresp,   // read response
   input  wire logic                   ext_clk_in,    // external count input
   input  wire logic                   gate_in,       // gate for accumulation
   input  wire logic                   sosc_in,       // secondary oscillator
   input  wire logic                   cpu_idle,      // processor in idle
   input  wire logic                   cpu_sleep,     // processor in sleep
   output logic                        irq            // level interrupt
);

   if (CW < 2 || CW > 16) begin : g_bad_width
      $error("counter width must be 2 to 16");
   end

   // ==========================================================================
   // address decode
   // ==========================================================================
   function automatic sbit_reg_t decode(input logic [SBIT_ADDR_W-1:0] a);
      sbit_reg_t r;
      r = REG_NONE;
      if (a[7:4] == ADDR_CTRL[7:4]) r = REG_CTRL;
      if (a[7:4] == ADDR_COUNT[7:4]) r = REG_COUNT;
      if (a[7:4] == ADDR_PERIOD[7:4]) r = REG_PERIOD;
      if (a[7:2] == ADDR_STATUS[7:2]) r = REG_STATUS;
      if (a[7:2] == ADDR_MASK[7:2]) r = REG_MASK;
      if (a[7:2] == ADDR_CONFIG[7:2]) r = REG_CONFIG;
      return r;
   endfunction

   // aliases only exist on the first three banks
   function automatic logic [31:0] apply(input logic [31:0] old, input logic [1:0] op,
                                         input logic [31:0] dat, input logic [31:0] be);
      logic [31:0] r;
      case (sbit_op_t'(op))
         OP_CLR:  r = old & ~(dat & be);
         OP_SET:  r = old | (dat & be);
         OP_INV:  r = old ^ (dat & be);
         default: r = (old & ~be) | (dat & be);
      endcase
      return r;
   endfunction

   // ==========================================================================
   // state
   // ==========================================================================
   logic [31:0]            ctrl_q, ctrl_d;
   logic [CW-1:0]          cnt_q, cnt_d, period_q, period_d;
   logic [ST_W-1:0]        st_q, st_d, mask_q, mask_d;
   logic                   async_q, async_d;
   logic                   ext_q, ext_d, sosc_q, sosc_d, gate_q, gate_d;
   logic                   aw_full_q, aw_full_d, w_full_q, w_full_d;
   logic [SBIT_ADDR_W-1:0] awaddr_q, awaddr_d;
   logic [31:0]            wdata_q, wdata_d;
   logic [3:0]             wstrb_q, wstrb_d;
   logic                   awready_d, wready_d, bvalid_d, arready_d, rvalid_d, irq_d;
   logic [1:0]             bresp_d, rresp_d;
   logic [31:0]            rdata_d;

   sbit_ctrl_t             c;
   sbit_reg_t              wr_reg, rd_reg;
   logic                   do_write, ar_take, cnt_wr;
   logic                   src_tick, run, ps_tick, inc, wrap, gate_close, gated;
   logic [31:0]            be, ctrl_rd;

   assign c        = sbit_ctrl_of(ctrl_q);
   assign wr_reg   = decode(awaddr_q);
   assign rd_reg   = decode(s_axi_araddr);
   assign do_write = aw_full_q && w_full_q && !s_axi_bvalid;
   assign ar_take  = s_axi_arvalid && s_axi_arready;
   assign cnt_wr   = do_write && (wr_reg == REG_COUNT);
   assign be       = {{8{wstrb_q[3]}}, {8{wstrb_q[2]}}, {8{wstrb_q[1]}}, {8{wstrb_q[0]}}};

   // ==========================================================================
   // count source, gating and prescaler
   // ==========================================================================
   assign gated = c.gate_en && !c.clock_source_select;
   always_comb begin
      // internal clock ticks every cycle, or while gate_in is high when gated; external sources count rising edges
      if (!c.clock_source_select) begin
         src_tick = gated ? gate_in : 1'b1;
      end else if (async_q) begin
         src_tick = sosc_in && !sosc_q;
      end else begin
         src_tick = ext_clk_in && !ext_q;
      end
      // sleep stops the system clock in every mode but the asynchronous one
      run = c.on
            && !(cpu_idle && c.stop_when_idle)
            && !(cpu_sleep && !(c.clock_source_select && async_q));
      gate_close = run && gated && gate_q && !gate_in;
   end

   sbit_prescaler u_ps (
      .clk      (clk),
      .rst      (rst),
      .clear    (!c.on),
      .tick_in  (src_tick && run),
      .ps_sel   (c.ps_sel),
      .tick_out (ps_tick)
   );

   assign inc  = ps_tick;
   assign wrap = inc && (cnt_q == period_q);

   // ==========================================================================
   // registers and counter
   // ==========================================================================
   always_comb begin
      ctrl_d   = ctrl_q;
      period_d = period_q;
      mask_d   = mask_q;
      async_d  = async_q;
      cnt_d    = cnt_q;
      ext_d    = ext_clk_in;
      sosc_d   = sosc_in;
      gate_d   = gate_in;
      if (wrap) begin
         cnt_d = '0;
      end else if (inc) begin
         cnt_d = cnt_q + CW'(1);
      end
      // a software write to the count takes precedence over a tick
      if (do_write) begin
         case (wr_reg)
            REG_CTRL:   ctrl_d   = apply(ctrl_q, awaddr_q[3:2], wdata_q, be) & CTRL_WMASK;
            REG_COUNT:  cnt_d    = CW'(apply(32'(cnt_q), awaddr_q[3:2], wdata_q, be));
            REG_PERIOD: period_d = CW'(apply(32'(period_q), awaddr_q[3:2], wdata_q, be));
            REG_MASK:   mask_d   = (mask_q & ~be[ST_W-1:0]) | (wdata_q[ST_W-1:0] & be[ST_W-1:0]);
            REG_CONFIG: async_d  = be[CFG_ASYNC_BIT] ? wdata_q[CFG_ASYNC_BIT] : async_q;
            default:    ctrl_d   = ctrl_q;
         endcase
      end
      // read clears the status; a same-cycle event still lands
      st_d = st_q;
      if (ar_take && rd_reg == REG_STATUS) begin
         st_d = '0;
      end
      if (wrap) st_d[ST_WRAP_BIT] = 1'b1;
      if (gate_close) st_d[ST_GATE_BIT] = 1'b1;
      irq_d = |(st_d & mask_d);
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         ctrl_q   <= CTRL_RST;
         cnt_q    <= '0;
         period_q <= CW'(PERIOD_RST);
         st_q     <= '0;
         mask_q   <= MASK_RST;
         async_q  <= 1'b0;
         ext_q    <= 1'b0;
         sosc_q   <= 1'b0;
         gate_q   <= 1'b0;
         irq      <= 1'b0;
      end else begin
         ctrl_q   <= ctrl_d;
         cnt_q    <= cnt_d;
         period_q <= period_d;
         st_q     <= st_d;
         mask_q   <= mask_d;
         async_q  <= async_d;
         ext_q    <= ext_d;
         sosc_q   <= sosc_d;
         gate_q   <= gate_d;
         irq      <= irq_d;
      end
   end

   // ==========================================================================
   // AXI4-Lite handshakes
   // ==========================================================================
   always_comb begin
      ctrl_rd = ctrl_q;
      if (c.clock_source_select) ctrl_rd[CTRL_GATE_BIT] = 1'b0;
      aw_full_d = aw_full_q ? !do_write : (s_axi_awvalid && s_axi_awready);
      w_full_d  = w_full_q ? !do_write : (s_axi_wvalid && s_axi_wready);
      awaddr_d  = (s_axi_awvalid && s_axi_awready) ? s_axi_awaddr : awaddr_q;
      wdata_d   = (s_axi_wvalid && s_axi_wready) ? s_axi_wdata : wdata_q;
      wstrb_d   = (s_axi_wvalid && s_axi_wready) ? s_axi_wstrb : wstrb_q;
      awready_d = !aw_full_d;
      wready_d  = !w_full_d;
      bvalid_d  = do_write || (s_axi_bvalid && !s_axi_bready);
      bresp_d   = s_axi_bresp;
      if (do_write) bresp_d = (wr_reg == REG_NONE) ? RESP_SLVERR : RESP_OKAY;
      rvalid_d  = ar_take || (s_axi_rvalid && !s_axi_rready);
      arready_d = !rvalid_d;
      rdata_d   = s_axi_rdata;
      rresp_d   = s_axi_rresp;
      if (ar_take) begin
         rresp_d = RESP_OKAY;
         case (rd_reg)
            REG_CTRL:   rdata_d = ctrl_rd;
            REG_COUNT:  rdata_d = 32'(cnt_q);
            REG_PERIOD: rdata_d = 32'(period_q);
            REG_STATUS: rdata_d = 32'(st_q);
            REG_MASK:   rdata_d = 32'(mask_q);
            REG_CONFIG: rdata_d = 32'(async_q);
            default: begin
               rdata_d = 32'h0000_0000;
               rresp_d = RESP_SLVERR;
            end
         endcase
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         aw_full_q     <= 1'b0;
         w_full_q      <= 1'b0;
         awaddr_q      <= '0;
         wdata_q       <= 32'h0000_0000;
         wstrb_q       <= 4'h0;
         s_axi_awready <= 1'b1;
         s_axi_wready  <= 1'b1;
         s_axi_bvalid  <= 1'b0;
         s_axi_bresp   <= RESP_OKAY;
         s_axi_arready <= 1'b1;
         s_axi_rvalid  <= 1'b0;
         s_axi_rdata   <= 32'h0000_0000;
         s_axi_rresp   <= RESP_OKAY;
      end else begin
         aw_full_q     <= aw_full_d;
         w_full_q      <= w_full_d;
         awaddr_q      <= awaddr_d;
         wdata_q       <= wdata_d;
         wstrb_q       <= wstrb_d;
         s_axi_awready <= awready_d;
         s_axi_wready  <= wready_d;
         s_axi_bvalid  <= bvalid_d;
         s_axi_bresp   <= bresp_d;
         s_axi_arready <= arready_d;
         s_axi_rvalid  <= rvalid_d;
         s_axi_rdata   <= rdata_d;
         s_axi_rresp   <= rresp_d;
      end
   end

   // ==========================================================================
   // checks
   // ==========================================================================
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);

   logic [31:0] clr_bits;
   logic        st_rd;
   assign clr_bits = wdata_q & be & CTRL_WMASK;
   assign st_rd    = ar_take && (rd_reg == REG_STATUS);

   sequence s_fast_tick;
      ps_tick && c.ps_sel == 3'h1 && src_tick && run;
   endsequence

   sequence s_stopped;
      !cnt_wr && !inc;
   endsequence

   chk_wrap_zero: assert property (wrap && !cnt_wr |=> cnt_q == '0)
      else $error("counter did not wrap to zero at period");
   chk_inc_step: assert property (
      inc && !wrap && !cnt_wr |=> cnt_q == $past(cnt_q) + CW'(1))
      else $error("counter did not step by one");
   chk_off_hold: assert property (!c.on && !cnt_wr |=> $stable(cnt_q))
      else $error("counter moved while disabled");
   chk_idle_stop: assert property (
      cpu_idle && c.stop_when_idle && !cnt_wr |=> $stable(cnt_q))
      else $error("counter moved in idle with stop-in-idle set");
   chk_sleep_stop: assert property (
      cpu_sleep && !(c.clock_source_select && async_q) |-> s_stopped)
      else $error("synchronous mode counted in sleep");
   chk_gate_read: assert property (
      ar_take && rd_reg == REG_CTRL && c.clock_source_select |=> !s_axi_rdata[CTRL_GATE_BIT])
      else $error("gate bit read as one with external clock");
   chk_ps_half: assert property (
      s_fast_tick ##1 (src_tick && run && c.ps_sel == 3'h1 && c.on) |-> !ps_tick)
      else $error("1:2 prescaler passed two ticks in a row");
   chk_alias_clr: assert property (
      do_write && wr_reg == REG_CTRL && awaddr_q[3:2] == OP_CLR
      |=> (ctrl_q & $past(clr_bits)) == 32'h0000_0000)
      else $error("clear alias left a bit set");
   // the flag may only drop after a read of the status register
   chk_flag_set: assert property (
      wrap |=> st_q[ST_WRAP_BIT] ##1 (st_q[ST_WRAP_BIT] || $past(st_rd)))
      else $error("wrap flag not raised");

endmodule

`default_nettype wire

// ### verification/sbit_src_model.sv
/*
 * Far-side source model: external event pin and secondary oscillator.
 * Assumes the caller's clk is the timer's system clock.
 */
`timescale 1ns/1ns
`default_nettype none

module sbit_src_model (
   input  wire logic clk,        // system clock
   output logic      ext_clk_in, // external event line
   output logic      sosc_in     // secondary oscillator line
);
   // both lines rest low between bursts, as an idle event pin would
   initial begin
      ext_clk_in = 1'h0;
      sosc_in    = 1'h0;
   end

   // ==========================================================================
   // n pulses, each gap cycles high then gap cycles low
   // ==========================================================================
   task automatic pulse(input logic sel, input int n, input int gap);
      repeat (n) begin
         @(posedge clk);
         if (sel)
            sosc_in <= 1'h1;
         else
            ext_clk_in <= 1'h1;
         repeat (gap) @(posedge clk);
         ext_clk_in <= 1'h0;
         sosc_in    <= 1'h0;
         repeat (gap) @(posedge clk);
      end
   endtask
endmodule

`default_nettype wire

// ### verification/tb.sv
/*
 * Self-checking bench of the interval timer over AXI4-Lite.
 * Assumes sbit_pkg and sbit_src_model are compiled first.
 */
`timescale 1ns/1ns
`default_nettype none

module tb;
   import sbit_pkg::*;
   logic        clk, rst, awv, awr, wv, wrd, bv, br, arv, arr, rv, rr;
   logic        ext, sosc, gate, idle, slp, irq;
   logic [7:0]  awa, ara;
   logic [31:0] wd, rdat, d;
   logic [1:0]  bresp, rresp, r;
   int          n_mismatch, checked, k;
   localparam logic [31:0] ON   = 32'h1 << CTRL_ON_BIT;
   localparam logic [31:0] IDLE_STOP = 32'h1 << CTRL_IDLE_BIT;
   localparam logic [31:0] GATE      = 32'h1 << CTRL_GATE_BIT;
   localparam logic [31:0] EXT_SRC   = 32'h1 << CTRL_SRC_BIT;

   sbit_timer dut (.clk(clk), .rst(rst), .s_axi_awvalid(awv), .s_axi_awready(awr),
      .s_axi_awaddr(awa), .s_axi_wvalid(wv), .s_axi_wready(wrd), .s_axi_wdata(wd),
      .s_axi_wstrb(4'hF), .s_axi_bvalid(bv), .s_axi_bready(br), .s_axi_bresp(bresp),
      .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_araddr(ara), .s_axi_rvalid(rv),
      .s_axi_rready(rr), .s_axi_rdata(rdat), .s_axi_rresp(rresp), .ext_clk_in(ext),
      .gate_in(gate), .sosc_in(sosc), .cpu_idle(idle), .cpu_sleep(slp), .irq(irq));
   sbit_src_model src (.clk(clk), .ext_clk_in(ext), .sosc_in(sosc));

   // ==========================================================================
   // bus tasks: ready is a register, so its negedge value is what the edge sees
   // ==========================================================================
   task automatic wr(input logic [7:0] a, input logic [31:0] v);
      logic ta, tw, tb_;
      @(posedge clk);
      awa <= a;
      wd  <= v;
      awv <= 1'h1;
      wv  <= 1'h1;
      br  <= 1'h1;
      do begin
         @(negedge clk);
         ta  = awv & awr;
         tw  = wv & wrd;
         tb_ = bv;
         r   = bresp;
         @(posedge clk);
         if (ta) awv <= 1'h0;
         if (tw) wv <= 1'h0;
      end while (tb_ !== 1'h1);
      br <= 1'h0;
   endtask

   task automatic rd(input logic [7:0] a);
      logic ta, tb_;
      @(posedge clk);
      ara <= a;
      arv <= 1'h1;
      rr  <= 1'h1;
      do begin
         @(negedge clk);
         ta  = arv & arr;
         tb_ = rv;
         d   = rdat;
         r   = rresp;
         @(posedge clk);
         if (ta) arv <= 1'h0;
      end while (tb_ !== 1'h1);
      rr <= 1'h0;
   endtask

   task automatic cmp(input logic [31:0] g, input logic [31:0] lo, input logic [31:0] hi);
      checked++;
      if ((g >= lo && g <= hi) !== 1'h1) begin
         n_mismatch++;
         $display("MISMATCH %0t got %h want %h..%h", $time, g, lo, hi);
      end
   endtask

   task automatic rc(input logic [7:0] a, input logic [31:0] lo, input logic [31:0] hi);
      rd(a);
      cmp(d, lo, hi);
   endtask

   task automatic close_out;
      if (n_mismatch == 0 && checked > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask

   // ==========================================================================
   // scenarios
   // ==========================================================================
   task automatic t_reset;
      rc(ADDR_CTRL, CTRL_RST, CTRL_RST);
      rc(ADDR_PERIOD, PERIOD_RST, PERIOD_RST);
      rc(ADDR_MASK, 32'h0, 32'h0);
      rc(8'hFC, 32'h0, 32'h0);
      cmp(r, RESP_SLVERR, RESP_SLVERR);
      wr(8'hFC, 32'hFFFF);
      cmp(r, RESP_SLVERR, RESP_SLVERR);
   endtask

   task automatic t_alias;
      wr(ADDR_PERIOD, 32'h1234);
      wr(ADDR_PERIOD + 8'h8, 32'h00F0);
      rc(ADDR_PERIOD, 32'h12F4, 32'h12F4);
      wr(ADDR_PERIOD + 8'h4, 32'h0204);
      rc(ADDR_PERIOD, 32'h10F0, 32'h10F0);
      wr(ADDR_PERIOD + 8'hC, 32'hFFFF);
      rc(ADDR_PERIOD, 32'hEF0F, 32'hEF0F);
      wr(ADDR_CTRL, GATE | EXT_SRC);
      rc(ADDR_CTRL, EXT_SRC, EXT_SRC);
      wr(ADDR_CTRL, GATE | 32'h78);
      rc(ADDR_CTRL, GATE | 32'h78, GATE | 32'h78);
      wr(ADDR_CTRL + 8'h4, GATE | 32'h10);
      rc(ADDR_CTRL, 32'h68, 32'h68);
      wr(ADDR_PERIOD, 32'hFFFF);
   endtask

   // each code runs 1024 cycles; bus latency allows a few extra ticks
   task automatic t_prescale;
      int div;
      for (k = 0; k < 8; k++) begin
         div = (k == 7) ? 256 : (1 << k);
         wr(ADDR_CTRL, 32'h0);
         wr(ADDR_COUNT, 32'h0);
         wr(ADDR_CTRL, ON | (k << CTRL_PS_LSB));
         repeat (1024) @(posedge clk);
         wr(ADDR_CTRL, 32'h0);
         rc(ADDR_COUNT, 1024 / div, 1032 / div + 1);
         rc(ADDR_COUNT, d, d);
      end
   endtask

   task automatic t_wrap;
      wr(ADDR_COUNT, 32'h0);
      wr(ADDR_PERIOD, 32'h4);
      wr(ADDR_MASK, 32'h1);
      wr(ADDR_CTRL, ON | EXT_SRC);
      src.pulse(1'h0, 4, 2);
      rc(ADDR_COUNT, 32'h4, 32'h4);
      rc(ADDR_STATUS, 32'h0, 32'h0);
      src.pulse(1'h0, 1, 2);
      rc(ADDR_COUNT, 32'h0, 32'h0);
      cmp(irq, 32'h1, 32'h1);
      rc(ADDR_STATUS, 32'h1, 32'h1);
      rc(ADDR_STATUS, 32'h0, 32'h0);
      cmp(irq, 32'h0, 32'h0);
      wr(ADDR_PERIOD, 32'hFFFF);
   endtask

   task automatic t_sleep;
      wr(ADDR_COUNT, 32'h0);
      wr(ADDR_CONFIG, 32'h1);
      @(posedge clk) slp <= 1'h1;
      src.pulse(1'h1, 3, 3);
      src.pulse(1'h0, 2, 2);
      rc(ADDR_COUNT, 32'h3, 32'h3);
      wr(ADDR_CONFIG, 32'h0);
      src.pulse(1'h0, 2, 2);
      rc(ADDR_COUNT, 32'h3, 32'h3);
      @(posedge clk) slp <= 1'h0;
      wr(ADDR_CTRL, 32'h0);
   endtask

   task automatic t_idle_gate;
      wr(ADDR_COUNT, 32'h0);
      @(posedge clk) idle <= 1'h1;
      wr(ADDR_CTRL, ON | IDLE_STOP);
      repeat (100) @(posedge clk);
      wr(ADDR_CTRL, 32'h0);
      rc(ADDR_COUNT, 32'h0, 32'h0);
      wr(ADDR_CTRL, ON);
      repeat (100) @(posedge clk);
      wr(ADDR_CTRL, 32'h0);
      rc(ADDR_COUNT, 32'h64, 32'h6E);
      @(posedge clk) idle <= 1'h0;
      wr(ADDR_COUNT, 32'h0);
      wr(ADDR_MASK, 32'h2);
      wr(ADDR_CTRL, ON | GATE);
      repeat (50) @(posedge clk);
      gate <= 1'h1;
      repeat (40) @(posedge clk);
      gate <= 1'h0;
      repeat (50) @(posedge clk);
      wr(ADDR_CTRL, 32'h0);
      rc(ADDR_COUNT, 32'h27, 32'h29);
      cmp(irq, 32'h1, 32'h1);
      rc(ADDR_STATUS, 32'h2, 32'h2);
   endtask

   initial begin
      clk = 1'h0;
      forever #4 clk = ~clk;
   end

   initial begin
      repeat (60000) @(posedge clk);
      n_mismatch++;
      close_out();
   end

   initial begin
      {rst, awv, wv, br, arv, rr, gate, idle, slp} = 9'h100;
      {awa, ara, wd} = 48'h0;
      repeat (16) @(posedge clk);
      rst <= 1'h0;
      t_reset();
      t_alias();
      t_prescale();
      t_wrap();
      t_sleep();
      t_idle_gate();
      close_out();
   end
endmodule

`default_nettype wire
